/* lpsr_top.sv */
// Purpose: latched parallel-in / serial-out shift register with 3-state output
// Assumes: pins are sampled on link_clk; parallel words arrive on clk_sys
// Notes:   words cross from clk_sys to link_clk by a toggle handshake

`timescale 1ns/100ps

package lpsr_pkg;
  localparam int STAGES      = 8;
  localparam int FIFO_DEPTH  = 16;
  localparam int LAST_STAGE  = STAGES - 1;
  localparam logic [STAGES-1:0] STAGE_RESET = 8'h00;

  typedef enum logic [0:0]
  {
    LPSR_IDLE = 1'b0,
    LPSR_WAIT = 1'b1
  } lpsr_xfer_t;
endpackage

module lpsr_top
  import lpsr_pkg::*;
(
  // system clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // parallel word source, system domain
  input  wire logic              word_valid,
  input  wire logic [STAGES-1:0] word_data,
  output logic                   word_ready,
  // link clock
  input  wire logic              link_clk,
  // serial host pins
  input  wire logic              shift_clk_pin,
  input  wire logic              capture_clk_pin,
  input  wire logic              mode_shift_pin,
  input  wire logic              serial_in_pin,
  input  wire logic              out_enable_n_pin,
  // 3-state serial output
  output logic                   serial_out,
  output logic                   serial_out_oe
);

  // ==========================================================================
  // reset release, one copy per domain
  // ==========================================================================
  logic rst_sys_meta_n;
  logic rst_sys_n;
  logic rst_lnk_meta_n;
  logic rst_lnk_n;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sys_meta_n <= 1'b0;
      rst_sys_n      <= 1'b0;
    end
    else
    begin
      rst_sys_meta_n <= 1'b1;
      rst_sys_n      <= rst_sys_meta_n;
    end
  end

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_lnk_meta_n <= 1'b0;
      rst_lnk_n      <= 1'b0;
    end
    else
    begin
      rst_lnk_meta_n <= 1'b1;
      rst_lnk_n      <= rst_lnk_meta_n;
    end
  end

  // ==========================================================================
  // word buffer, system domain
  // ==========================================================================
  logic              fifo_out_valid;
  logic [STAGES-1:0] fifo_out_data;
  logic              fifo_out_ready;

  lpsr_fifo
  #(
    .WIDTH (STAGES),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .clk       (clk_sys),
    .rst_n     (rst_sys_n),
    .in_valid  (word_valid),
    .in_data   (word_data),
    .in_ready  (word_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_out_ready)
  );

  // ==========================================================================
  // handoff sender, system domain
  // ==========================================================================
  lpsr_xfer_t        xfer_state;
  logic              req_tgl;
  logic [STAGES-1:0] xfer_data;
  logic              ack_meta;
  logic              ack_sync;
  logic              ack_tgl_lnk;

  // the fifo only drains when the link has consumed the previous word,
  // so a host that never captures makes the buffer fill and stall the source
  assign fifo_out_ready = (xfer_state == LPSR_IDLE) && fifo_out_valid;

  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end
    else
    begin
      ack_meta <= ack_tgl_lnk;
      ack_sync <= ack_meta;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      xfer_state <= LPSR_IDLE;
      req_tgl    <= 1'b0;
    end
    else
    begin
      unique case (xfer_state)
        LPSR_IDLE:
        begin
          if (fifo_out_valid)
          begin
            req_tgl    <= !req_tgl;
            xfer_state <= LPSR_WAIT;
          end
        end
        LPSR_WAIT:
        begin
          if (ack_sync == req_tgl)
          begin
            xfer_state <= LPSR_IDLE;
          end
        end
      endcase
    end
  end

  // data held stable while the toggle travels across
  always_ff @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      xfer_data <= STAGE_RESET;
    end
    else if (fifo_out_ready)
    begin
      xfer_data <= fifo_out_data;
    end
  end

  // ==========================================================================
  // handoff receiver, link domain
  // ==========================================================================
  logic              req_meta;
  logic              req_sync;
  logic              req_seen;
  logic [STAGES-1:0] par_word;
  logic              par_fresh;
  logic              capture_rise;

  always_ff @(posedge link_clk or negedge rst_lnk_n)
  begin
    if (!rst_lnk_n)
    begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
    end
    else
    begin
      req_meta <= req_tgl;
      req_sync <= req_meta;
      req_seen <= req_sync;
    end
  end

  // parallel inputs: the last word delivered stays on them until replaced
  always_ff @(posedge link_clk or negedge rst_lnk_n)
  begin
    if (!rst_lnk_n)
    begin
      par_word <= STAGE_RESET;
    end
    else if (req_sync != req_seen)
    begin
      par_word <= xfer_data;
    end
  end

  // next word is requested once the present one has been captured
  always_ff @(posedge link_clk or negedge rst_lnk_n)
  begin
    if (!rst_lnk_n)
    begin
      par_fresh   <= 1'b0;
      ack_tgl_lnk <= 1'b0;
    end
    else if (req_sync != req_seen)
    begin
      par_fresh <= 1'b1;
    end
    else if (capture_rise && par_fresh)
    begin
      par_fresh   <= 1'b0;
      ack_tgl_lnk <= !ack_tgl_lnk;
    end
  end

  // ==========================================================================
  // pin synchronisers and edge detection, link domain
  // ==========================================================================
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [1:0] clk_prev;
  logic       shift_rise;
  logic       mode_shift;
  logic       serial_in;
  logic       out_enable_n;

  always_ff @(posedge link_clk or negedge rst_lnk_n)
  begin
    if (!rst_lnk_n)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      clk_prev <= 2'h0;
    end
    else
    begin
      pin_meta <= {out_enable_n_pin, serial_in_pin, mode_shift_pin,
                   capture_clk_pin, shift_clk_pin};
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[1:0];
    end
  end

  assign shift_rise   = pin_sync[0] && !clk_prev[0];
  assign capture_rise = pin_sync[1] && !clk_prev[1];
  assign mode_shift   = pin_sync[2];
  assign serial_in    = pin_sync[3];
  assign out_enable_n = pin_sync[4];

  // ==========================================================================
  // storage latch and shift chain, link domain
  // ==========================================================================
  // bit 0 is stage A, the top bit is stage H
  logic [STAGES-1:0] storage_latch;
  logic [STAGES-1:0] shift_chain;

  // contents are cleared by the internal reset only; no pin resets them
  always_ff @(posedge link_clk or negedge rst_lnk_n)
  begin
    if (!rst_lnk_n)
    begin
      storage_latch <= STAGE_RESET;
    end
    else if (capture_rise)
    begin
      storage_latch <= par_word;
    end
  end

  always_ff @(posedge link_clk or negedge rst_lnk_n)
  begin
    if (!rst_lnk_n)
    begin
      shift_chain <= STAGE_RESET;
    end
    else if (!mode_shift)
    begin
      // parallel mode: a capture edge passes straight through the latch
      shift_chain <= capture_rise ? par_word : storage_latch;
    end
    else if (shift_rise)
    begin
      shift_chain <= {shift_chain[LAST_STAGE-1:0], serial_in};
    end
  end

  // holds in shift mode without an edge; enable never touches contents

  // ==========================================================================
  // 3-state output
  // ==========================================================================
  always_ff @(posedge link_clk or negedge rst_lnk_n)
  begin
    if (!rst_lnk_n)
    begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end
    else
    begin
      serial_out    <= shift_chain[LAST_STAGE];
      serial_out_oe <= !out_enable_n;
    end
  end

endmodule // lpsr_top

/* lpsr_fifo.sv */
// Purpose: synchronous word buffer between the system port and the link handoff
// Assumes: single clock, active-low reset already synchronised by the caller
// Notes:   full and empty are exact; storage is flip-flops addressed by index
`timescale 1ns/100ps

module lpsr_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================================
  // storage and pointers
  // ==========================================================================
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_write;
  logic             do_read;
  logic             full;
  logic             empty;

  // extra pointer bit tells full from empty when the indices match
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign do_write  = in_valid && !full;
  assign do_read   = out_ready && !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (do_write)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
    end
    else if (do_write)
    begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ptr <= '0;
    end
    else if (do_read)
    begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule // lpsr_fifo

/* lpsr_top_assertions.sv */
// Purpose: port assertions for lpsr_top
// Assumes: host pins held >=3 link_clk
// Notes:   outputs follow pins by 3..4 link_clk
`timescale 1ns/100ps

module lpsr_top_checker
(
  // clock and reset
  input wire logic link_clk,
  input wire logic rstn,
  // host pins
  input wire logic shift_clk_pin,
  input wire logic capture_clk_pin,
  input wire logic mode_shift_pin,
  input wire logic out_enable_n_pin,
  // serial output
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] quiet;
  logic [3:0] oe_hi_cnt;
  logic [3:0] since;
  // ====
  // helper counters, saturating at 15
  // plain clocked reset, so the sampled-value calls below see one clock only
  always_ff @(posedge link_clk)
  begin
    if (!rstn)
      quiet <= 4'h0;
    else if (!mode_shift_pin || $changed({shift_clk_pin, capture_clk_pin}))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end
  always_ff @(posedge link_clk)
  begin
    if (!rstn)
      oe_hi_cnt <= 4'h0;
    else if (!out_enable_n_pin)
      oe_hi_cnt <= 4'h0;
    else if (oe_hi_cnt != 4'hf)
      oe_hi_cnt <= oe_hi_cnt + 4'h1;
  end
  // cycles since any pin event that may move the chain
  always_ff @(posedge link_clk)
  begin
    if (!rstn)
      since <= 4'h0;
    else if ($rose(shift_clk_pin) || $rose(capture_clk_pin) || $changed(mode_shift_pin))
      since <= 4'h0;
    else if (since != 4'hf)
      since <= since + 4'h1;
  end
  // ====
  // properties
  property p_oe_off;
    $rose(out_enable_n_pin) |-> ##[2:5] !serial_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe not off");
  property p_oe_stay;
    oe_hi_cnt > 4'h4 |-> !serial_out_oe;
  endproperty
  a_oe_stay: assert property (p_oe_stay) else $error("oe on");
  property p_oe_on;
    $fell(out_enable_n_pin) |-> ##[2:5] serial_out_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe not on");
  property p_quiet;
    quiet > 4'h5 |-> $stable(serial_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("out moved");
  property p_cause;
    $changed(serial_out) |-> since < 4'h6;
  endproperty
  a_cause: assert property (p_cause) else $error("out moved alone");
  property p_low;
    $rose(shift_clk_pin) && !mode_shift_pin && since > 4'h5
      ##1 (!mode_shift_pin && !capture_clk_pin)[*6] |-> serial_out == $past(serial_out, 6);
  endproperty
  a_low: assert property (p_low) else $error("shift in load mode");
  property p_cap;
    $rose(capture_clk_pin) && mode_shift_pin && since > 4'h5
      ##1 (mode_shift_pin && !shift_clk_pin)[*6] |-> serial_out == $past(serial_out, 6);
  endproperty
  a_cap: assert property (p_cap) else $error("capture moved out");
  property p_oe_data;
    $changed(out_enable_n_pin) && since > 4'h5
      ##1 (since != 4'h0)[*6] |-> serial_out == $past(serial_out, 6);
  endproperty
  a_oe_data: assert property (p_oe_data) else $error("oe moved out");
  c_load: cover property ($rose(capture_clk_pin) && !mode_shift_pin);
  c_both: cover property ($rose(capture_clk_pin) && $rose(shift_clk_pin));
  c_hiz: cover property ($rose(out_enable_n_pin));
endmodule // lpsr_top_checker

bind lpsr_top lpsr_top_checker i_chk
(
  .link_clk        (link_clk),
  .rstn            (rstn),
  .shift_clk_pin   (shift_clk_pin),
  .capture_clk_pin (capture_clk_pin),
  .mode_shift_pin  (mode_shift_pin),
  .out_enable_n_pin(out_enable_n_pin),
  .serial_out      (serial_out),
  .serial_out_oe   (serial_out_oe)
);

/* lpsr_host_model.sv */
// Purpose: serial host driving the lpsr_top pins
// Assumes: called from one bench process
// Notes:   pins change only after link_clk edges
`timescale 1ns/100ps

module lpsr_host_model
(
  // link clock
  input wire logic link_clk,
  // host pins
  output logic     shift_clk_pin,
  output logic     capture_clk_pin,
  output logic     mode_shift_pin,
  output logic     serial_in_pin,
  output logic     out_enable_n_pin
);
  initial
  begin
    {shift_clk_pin, capture_clk_pin, serial_in_pin, out_enable_n_pin} = 4'h0;
    mode_shift_pin = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // each level held 3 edges so the synchronisers see it
  task automatic pulse(input logic s, input logic c, input logic d);
    hold(1);
    serial_in_pin <= d;
    hold(3);
    shift_clk_pin <= s;
    capture_clk_pin <= c;
    hold(3);
    shift_clk_pin <= 1'b0;
    capture_clk_pin <= 1'b0;
    hold(4);
  endtask
  task automatic set_pins(input logic m, input logic oe_n);
    hold(1);
    mode_shift_pin <= m;
    out_enable_n_pin <= oe_n;
    hold(6);
  endtask
endmodule // lpsr_host_model

/* lpsr_top_bench.sv */
// Purpose: self-checking bench for lpsr_top
// Assumes: pins come from lpsr_host_model
// Notes:   outputs read once the pin latency has run out
`timescale 1ns/100ps

module lpsr_top_bench;
  import lpsr_pkg::*;
  logic              clk_sys;
  logic              link_clk;
  logic              rstn;
  logic              word_valid;
  logic [STAGES-1:0] word_data;
  logic              word_ready;
  logic              sclk, cclk, mode, sin, oe_n;
  logic              serial_out;
  logic              serial_out_oe;
  wire               qh = serial_out_oe ? serial_out : 1'bz;
  int                n_errors;
  int                checked;
  logic [STAGES-1:0] last;

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end

  lpsr_top i_dut
  (
    .clk_sys(clk_sys), .rstn(rstn),
    .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
    .link_clk(link_clk), .shift_clk_pin(sclk), .capture_clk_pin(cclk),
    .mode_shift_pin(mode), .serial_in_pin(sin), .out_enable_n_pin(oe_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );
  lpsr_host_model i_host
  (
    .link_clk(link_clk), .shift_clk_pin(sclk), .capture_clk_pin(cclk),
    .mode_shift_pin(mode), .serial_in_pin(sin), .out_enable_n_pin(oe_n)
  );

  // ====
  // checks and verdict
  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      n_errors++;
      $display("[ERR] %0t count %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [STAGES-1:0] w(input int i);
    return 8'h5a + 8'h1d * i[7:0];
  endfunction
  // valid stays up between attempts; ready is read mid-cycle, where it is settled
  task automatic offer(input logic [STAGES-1:0] d, output logic took);
    word_valid <= 1'b1;
    word_data <= d;
    @(negedge clk_sys);
    took = word_ready;
    @(posedge clk_sys);
  endtask
  task automatic push(input logic [STAGES-1:0] d);
    logic took;
    int   n;
    took = 1'b0;
    @(posedge clk_sys);
    for (n = 0; n < 40 && !took; n++)
      offer(d, took);
    word_valid <= 1'b0;
    chk(took, 1'b1);
    repeat (20) @(posedge clk_sys);
  endtask

  // ====
  // scenarios
  // buffer plus the one word parked in the handoff until a capture
  task automatic t_fill();
    logic took;
    int   n;
    int   taken;
    took  = 1'b1;
    taken = 0;
    for (n = 0; n < 30 && took; n++)
    begin
      offer(w(n), took);
      if (took)
        taken++;
    end
    word_valid <= 1'b0;
    chk_cnt(taken, FIFO_DEPTH + 1);
    $display("fill done");
  endtask
  task automatic t_drain();
    int n;
    i_host.set_pins(1'b0, 1'b0);
    for (n = 0; n < FIFO_DEPTH + 1; n++)
    begin
      last = w(n);
      i_host.pulse(1'b0, 1'b1, 1'b0);
      chk(serial_out, last[7]);
      chk(qh, last[7]);
      repeat (10) @(posedge clk_sys);
    end
    chk(word_ready, 1'b1);
    $display("drain done");
  endtask
  task automatic t_shift();
    logic [15:0] sbits;
    int          k;
    sbits = 16'h4d2b;
    push(8'h43);
    i_host.set_pins(1'b1, 1'b0);
    i_host.pulse(1'b0, 1'b1, 1'b0);
    chk(serial_out, last[7]);
    push(8'hb6);
    for (k = 1; k < 16; k++)
    begin
      i_host.pulse(1'b1, k == 3, sbits[k-1]);
      chk(serial_out, (k < 8) ? last[7-k] : sbits[(k+8)%16]);
    end
    i_host.set_pins(1'b0, 1'b0);
    chk(serial_out, 1'b1);
    $display("shift done");
  endtask
  task automatic t_pins();
    i_host.pulse(1'b1, 1'b0, 1'b0);
    chk(serial_out, 1'b1);
    i_host.set_pins(1'b0, 1'b1);
    chk(qh, 1'bz);
    chk(serial_out, 1'b1);
    i_host.set_pins(1'b0, 1'b0);
    chk(qh, 1'b1);
    $display("pins done");
  endtask

  initial
  begin
    #1_000_000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    rstn = 1'b0;
    word_valid = 1'b0;
    word_data = 8'h00;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    t_fill();
    t_drain();
    t_shift();
    t_pins();
    give_verdict();
  end
endmodule // lpsr_top_bench
